// ==== tfs_pkg.sv ====
// Purpose: constants for the transceiver fault status block
// Assumes: 20 MHz clock, register port with one-cycle read latency
// Notes: status word layout and register offsets
package tfs_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TX_ACTIVE_MAX_US = 4000;
    localparam int unsigned TX_ACTIVE_MAX_CYC =
        (TX_ACTIVE_MAX_US * (CLK_HZ / 1000000));
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
    localparam logic [3:0] ADDR_CTRL = 4'h3;
    localparam int unsigned BIT_POWER_UP = 3;
    localparam int unsigned BIT_OT_SHUTDOWN = 5;
    localparam int unsigned BIT_OT_WARNING = 6;
    localparam int unsigned BIT_TX_TIMEOUT = 7;
    localparam int unsigned BIT_ERROR = 11;
    localparam int unsigned BIT_MODE_EN = 13;
    localparam int unsigned BIT_MODE_STANDBY_SELECT_PIN = 14;
    localparam int unsigned BIT_PARITY = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0001;
    typedef enum logic [2:0] {
        normal_mode,
        receive_only_mode,
        standby_mode,
        sleep_mode,
        go_to_sleep_mode
    } tfs_mode_t;
endpackage

// ==== tfs_timer_if.sv ====
// Purpose: link between the fault logic and the active-time counter
// Assumes: one clock domain
// Notes: active holds while transmitter is active
`timescale 1ns/100ps
`default_nettype none
interface tfs_timer_if;
    logic active;
    logic expired;
    modport owner (output active, input expired);
    modport timer (input active, output expired);
endinterface
`default_nettype wire

// ==== tfs_active_timer.sv ====
// Purpose: times continuous transmitter activity
// Assumes: active is a level from the owner
// Notes: expired is a registered pulse-level once the limit is exceeded
`timescale 1ns/100ps
`default_nettype none
module tfs_active_timer #(
    parameter int unsigned LIMIT = 80000
) (
    input wire logic clk,
    input wire logic rst_n,
    tfs_timer_if.timer tif
);
    localparam int unsigned CW = $clog2(LIMIT + 2);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
    logic [CW-1:0] cnt_q;
    logic expired_q;

    // a zero limit would fire on the first active cycle
    if (LIMIT < 1) begin : g_bad_limit
        $error("limit must be at least one cycle");
    end

    // count up while active, restart whenever activity stops
    always_ff @(posedge clk) begin
        if (!rst_n || !tif.active) begin
            cnt_q <= '0;
        end else if (cnt_q <= LIMIT_C) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            expired_q <= 1'b0;
        end else begin
            expired_q <= tif.active && (cnt_q >= LIMIT_C);
        end
    end

    assign tif.expired = expired_q;
endmodule
`default_nettype wire

// ==== tfs_fault_status.sv ====
// Purpose: thermal and transmitter time-out protection with status word
// Assumes: all inputs synchronous to clk; mode and supply levels given
// Notes: status word cleared by read-out or by entry into normal mode
`timescale 1ns/100ps
`default_nettype none
module tfs_fault_status
    import tfs_pkg::*;
#(
    parameter int unsigned TX_MAX_CYC = TX_ACTIVE_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire tfs_mode_t op_mode,
    input wire logic temp_warning,
    input wire logic temp_shutdown,
    input wire logic supply_tx_ok,
    input wire logic supply_bat_ok,
    input wire logic transmit_gate_input,
    input wire logic bus_guardian_gate,
    output logic transmitter_enable,
    output logic error_indication_output,
    output logic irq
);
    localparam logic [15:0] IRQ_SRC_MASK = 16'(
        (1 << BIT_OT_WARNING) | (1 << BIT_OT_SHUTDOWN) |
        (1 << BIT_TX_TIMEOUT) | (1 << BIT_POWER_UP));

    logic ot_warn_q;
    logic ot_shut_q;
    logic tx_tout_q;
    logic power_up_q;
    logic supplies_seen_q;
    tfs_mode_t mode_prev_q;
    logic [15:0] irq_stat_q;
    logic [15:0] irq_mask_q;
    logic [15:0] ctrl_q;
    logic [15:0] rdata_q;
    logic tx_en_q;
    logic error_indication_output_q;
    logic irq_q;
    logic [15:0] status_word;
    logic [15:0] irq_events;
    logic enter_normal;
    logic sir_read;
    logic status_clear;
    logic in_normal;
    logic error_bit;
    logic tx_request;
    logic tout_event;
    logic warn_event;
    logic shut_event;
    logic pwr_event;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic wr_ctrl;
    logic [15:0] rd_mux;

    tfs_timer_if tif ();

    // refuse a limit the timer cannot serve and a layout that breaks
    // the fixed 16-bit word carried by the register port
    if (TX_MAX_CYC < 1) begin : g_bad_limit
        $error("active time limit too short");
    end
    if (DATA_W != 16) begin : g_bad_width
        $error("status word must be 16 bits wide");
    end
    if (BIT_PARITY != DATA_W - 1) begin : g_bad_parity
        $error("parity must sit in the top bit of the status word");
    end
    if (BIT_MODE_STANDBY_SELECT_PIN >= BIT_PARITY) begin : g_bad_mode
        $error("mode bits must sit below the parity bit");
    end
    if (BIT_TX_TIMEOUT >= BIT_ERROR) begin : g_bad_fault
        $error("fault bits must sit below the summary error bit");
    end

    function automatic logic even_parity(input logic [14:0] bits);
        even_parity = ^bits;
    endfunction

    function automatic logic [1:0] mode_bits(input tfs_mode_t m);
        case (m)
            normal_mode: mode_bits = 2'h3;
            receive_only_mode: mode_bits = 2'h2;
            default: mode_bits = 2'h0;
        endcase
    endfunction

    // one index decode shared by the write and read paths
    function automatic logic addr_is(input logic [3:0] a,
        input logic [3:0] idx);
        addr_is = (a == idx);
    endfunction

    assign in_normal = (op_mode == normal_mode);
    assign enter_normal = in_normal && (mode_prev_q != normal_mode);
    assign sir_read = reg_rd && addr_is(reg_addr, ADDR_STATUS);
    // register writes decoded once for all register processes
    assign wr_irq_stat = reg_wr && addr_is(reg_addr, ADDR_IRQ_STATUS);
    assign wr_irq_mask = reg_wr && addr_is(reg_addr, ADDR_IRQ_MASK);
    assign wr_ctrl = reg_wr && addr_is(reg_addr, ADDR_CTRL);
    // thermal events only count in normal mode
    assign warn_event = in_normal && temp_warning;
    assign shut_event = in_normal && temp_shutdown;
    // power-up fires on the first cycle with both supplies up;
    // a supply drop re-arms it so a later power cycle is seen again
    assign pwr_event = supply_tx_ok && supply_bat_ok && !supplies_seen_q;
    assign status_clear = sir_read || enter_normal;
    // gate low and guardian high means the transmitter is asked to drive
    assign tx_request = in_normal && !transmit_gate_input && bus_guardian_gate;
    assign tif.active = tx_request && tx_en_q;
    assign tout_event = tif.expired;
    assign error_bit = ot_warn_q || ot_shut_q || tx_tout_q;

    // status word assembly; power-up stays out of the error term
    always_comb begin
        status_word = 16'h0000;
        status_word[BIT_POWER_UP] = power_up_q;
        status_word[BIT_OT_SHUTDOWN] = ot_shut_q;
        status_word[BIT_OT_WARNING] = ot_warn_q;
        status_word[BIT_TX_TIMEOUT] = tx_tout_q;
        status_word[BIT_ERROR] = error_bit;
        {status_word[BIT_MODE_STANDBY_SELECT_PIN], status_word[BIT_MODE_EN]} =
            mode_bits(op_mode);
        status_word[BIT_PARITY] = even_parity(status_word[14:0]);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_prev_q <= standby_mode;
        end else begin
            mode_prev_q <= op_mode;
        end
    end

    // thermal detection, set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ot_warn_q <= 1'b0;
        end else if (warn_event) begin
            ot_warn_q <= 1'b1;
        end else if (status_clear) begin
            ot_warn_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ot_shut_q <= 1'b0;
        end else if (shut_event) begin
            ot_shut_q <= 1'b1;
        end else if (status_clear) begin
            ot_shut_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_tout_q <= 1'b0;
        end else if (tout_event) begin
            tx_tout_q <= 1'b1;
        end else if (status_clear) begin
            tx_tout_q <= 1'b0;
        end
    end

    // power-up bit set each time both supplies come up after reset or a supply drop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            supplies_seen_q <= 1'b0;
        end else if (supply_tx_ok && supply_bat_ok) begin
            supplies_seen_q <= 1'b1;
        end else begin
            supplies_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_up_q <= 1'b0;
        end else if (pwr_event) begin
            power_up_q <= 1'b1;
        end else if (status_clear) begin
            power_up_q <= 1'b0;
        end
    end

    // transmitter permission; mode is never touched here
    // re-enable waits for the registered fault bits, so a clear that
    // meets a fresh shutdown or time-out keeps the transmitter off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_en_q <= 1'b1;
        end else if (shut_event || tout_event) begin
            tx_en_q <= 1'b0;
        end else if (!ot_shut_q && !tx_tout_q && ctrl_q[0]) begin
            tx_en_q <= 1'b1;
        end else if (!ctrl_q[0]) begin
            tx_en_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            transmitter_enable <= 1'b0;
        end else begin
            transmitter_enable <= tx_en_q && tx_request;
        end
    end

    // error output low while a thermal bit stands, or the time-out bit in normal mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            error_indication_output_q <= 1'b1;
        end else begin
            error_indication_output_q <= !(ot_warn_q || ot_shut_q || (in_normal && tx_tout_q));
        end
    end
    assign error_indication_output = error_indication_output_q;

    // interrupt status: set by rising events, write one to clear
    // only the first cycle of a fault raises an interrupt event
    always_comb begin
        irq_events = 16'h0000;
        irq_events[BIT_OT_WARNING] = warn_event && !ot_warn_q;
        irq_events[BIT_OT_SHUTDOWN] = shut_event && !ot_shut_q;
        irq_events[BIT_TX_TIMEOUT] = tout_event && !tx_tout_q;
        irq_events[BIT_POWER_UP] = pwr_event;
    end

    // an event that meets a write-one-to-clear survives it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_q <= STATUS_RESET;
        end else if (wr_irq_stat) begin
            irq_stat_q <= ((irq_stat_q & ~reg_wdata) | irq_events)
                & IRQ_SRC_MASK;
        end else begin
            irq_stat_q <= (irq_stat_q | irq_events) & IRQ_SRC_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_mask_q <= MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask_q <= reg_wdata & IRQ_SRC_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata & CTRL_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end
    assign irq = irq_q;

    // read multiplexer; unmapped indexes read as zero
    always_comb begin
        rd_mux = 16'h0000;
        if (addr_is(reg_addr, ADDR_STATUS)) begin
            rd_mux = status_word;
        end else if (addr_is(reg_addr, ADDR_IRQ_STATUS)) begin
            rd_mux = irq_stat_q;
        end else if (addr_is(reg_addr, ADDR_IRQ_MASK)) begin
            rd_mux = irq_mask_q;
        end else if (addr_is(reg_addr, ADDR_CTRL)) begin
            rd_mux = ctrl_q;
        end
    end

    // read data stand only in the cycle after the strobe; the status
    // word is captured before the read-out clear takes effect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign reg_rdata = rdata_q;

    tfs_active_timer #(
        .LIMIT(TX_MAX_CYC)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tif(tif)
    );
endmodule
`default_nettype wire

// ==== tfs_host_model.sv ====
// Purpose: controller and host pins facing tfs_fault_status
// Assumes: bench gives mode and send commands
// Notes: pins change only just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module tfs_host_model
    import tfs_pkg::*;
(
    input wire logic clk,
    input wire tfs_mode_t mode_cmd,
    input wire logic send,
    output tfs_mode_t op_mode,
    output logic transmit_gate_input,
    output logic bus_guardian_gate
);
    initial begin
        op_mode = normal_mode;
        transmit_gate_input = 1'b1;
        bus_guardian_gate = 1'b0;
    end
    // a fresh normal command is one way the host clears time-outs
    always @(posedge clk) begin
        op_mode <= mode_cmd;
        transmit_gate_input <= !send;
        bus_guardian_gate <= send;
    end
endmodule
`default_nettype wire

// ==== tfs_fault_status_sva.sv ====
// Purpose: port checks for tfs_fault_status
// Assumes: one clock, synchronous reset
// Notes: shadow lock mirrors only the shutdown cause
`timescale 1ns/100ps
`default_nettype none
module tfs_fault_status_sva
    import tfs_pkg::*;
#(
    parameter int unsigned TX_MAX_CYC = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire tfs_mode_t op_mode,
    input wire logic temp_warning,
    input wire logic temp_shutdown,
    input wire logic transmit_gate_input,
    input wire logic bus_guardian_gate,
    input wire logic transmitter_enable,
    input wire logic error_indication_output
);
    int unsigned act_cnt;
    logic blk_q;
    tfs_mode_t mode_q;
    logic st_rd;
    logic nrm;
    assign st_rd = reg_rd && reg_addr == ADDR_STATUS;
    assign nrm = op_mode == normal_mode;
    function automatic logic [1:0] mbits(tfs_mode_t m);
        if (m == normal_mode) return 2'b11;
        return {m == receive_only_mode, 1'b0};
    endfunction
    always_ff @(posedge clk) begin
        if (!rst_n || !(nrm && !transmit_gate_input && bus_guardian_gate
            && transmitter_enable)) begin
            act_cnt <= 0;
        end else begin
            act_cnt <= act_cnt + 1;
        end
    end
    always_ff @(posedge clk) begin
        mode_q <= op_mode;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blk_q <= 1'b0;
        end else if (nrm && temp_shutdown) begin
            blk_q <= 1'b1;
        end else if (st_rd || (nrm && mode_q != normal_mode)) begin
            blk_q <= 1'b0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_status_rd;
        st_rd ##1 1'b1;
    endsequence
    sequence s_steady_rd;
        st_rd && $stable(op_mode) ##1 $stable(op_mode);
    endsequence
    shut_tx_off_a: assert property (
        nrm && temp_shutdown |-> ##[1:2] !transmitter_enable)
        else $error("transmitter left on after shutdown");
    therm_err_a: assert property (
        nrm && (temp_warning || temp_shutdown)
        |-> ##[1:3] !error_indication_output)
        else $error("error output not low after thermal event");
    lock_hold_a: assert property (
        blk_q && $past(blk_q) && $past(blk_q, 2) |-> !transmitter_enable)
        else $error("transmitter on before status clear");
    tx_limit_a: assert property (act_cnt <= TX_MAX_CYC + 3)
        else $error("transmitter active too long");
    tout_err_a: assert property (
        act_cnt == TX_MAX_CYC + 1 |-> ##[1:4] !error_indication_output)
        else $error("time-out not shown on error output");
    mode_bits_a: assert property (
        s_steady_rd |-> reg_rdata[14:13] == mbits(op_mode))
        else $error("mode bits wrong");
    parity_a: assert property (s_status_rd |-> ^reg_rdata == 1'b0)
        else $error("status parity odd");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data without read");
endmodule
bind tfs_fault_status tfs_fault_status_sva #(.TX_MAX_CYC(TX_MAX_CYC)) u_sva (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_mode(op_mode), .temp_warning(temp_warning),
    .temp_shutdown(temp_shutdown), .transmit_gate_input(transmit_gate_input),
    .bus_guardian_gate(bus_guardian_gate),
    .transmitter_enable(transmitter_enable),
    .error_indication_output(error_indication_output));
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for tfs_fault_status
// Assumes: 20 MHz clock, time-out limit cut to 20 cycles
// Notes: host pins come from tfs_host_model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    import tfs_pkg::*;
    localparam int unsigned TXM = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    tfs_mode_t op_mode;
    tfs_mode_t mode_cmd = normal_mode;
    logic t_warn = 1'b0;
    logic t_shut = 1'b0;
    logic sup_tx = 1'b0;
    logic sup_bat = 1'b0;
    logic send = 1'b0;
    logic gate;
    logic guard;
    logic tx_en;
    logic err_n;
    logic irq;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    initial forever #25 clk = ~clk;
    tfs_host_model u_tfs_host_model (.clk(clk), .mode_cmd(mode_cmd),
        .send(send), .op_mode(op_mode), .transmit_gate_input(gate),
        .bus_guardian_gate(guard));
    tfs_fault_status #(.TX_MAX_CYC(TXM)) u_tfs_fault_status (.clk(clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .op_mode(op_mode), .temp_warning(t_warn), .temp_shutdown(t_shut),
        .supply_tx_ok(sup_tx), .supply_bat_ok(sup_bat),
        .transmit_gate_input(gate), .bus_guardian_gate(guard),
        .transmitter_enable(tx_en), .error_indication_output(err_n),
        .irq(irq));
    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic host(input logic s, input tfs_mode_t m);
        @(posedge clk);
        send <= s;
        mode_cmd <= m;
    endtask
    task automatic heat(input logic w, input logic s);
        @(posedge clk);
        t_warn <= w;
        t_shut <= s;
        @(posedge clk);
        t_warn <= 1'b0;
        t_shut <= 1'b0;
    endtask
    task automatic sc_power();
        @(posedge clk);
        sup_tx <= 1'b1;
        sup_bat <= 1'b1;
        step(3);
        #1 `CHK(err_n, 1'b1)
        rd(ADDR_STATUS, 16'he008);
        rd(ADDR_STATUS, 16'h6000);
    endtask
    task automatic sc_warn();
        heat(1'b1, 1'b0);
        step(3);
        #1 `CHK(err_n, 1'b0)
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 16'h0040);
        step(2);
        #1 `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STATUS, 16'h0040);
        step(2);
        #1 `CHK(irq, 1'b0)
        rd(ADDR_IRQ_MASK, 16'h0040);
        rd(4'hf, 16'h0000);
        rd(ADDR_STATUS, 16'h6840);
        step(3);
        #1 `CHK(err_n, 1'b1)
    endtask
    task automatic sc_shut();
        host(1'b1, normal_mode);
        step(4);
        #1 `CHK(tx_en, 1'b1)
        heat(1'b0, 1'b1);
        step(2);
        #1 `CHK(tx_en, 1'b0)
        step(6);
        #1 `CHK(tx_en, 1'b0)
        rd(ADDR_STATUS, 16'h6820);
        step(3);
        #1 `CHK(tx_en, 1'b1)
        host(1'b0, normal_mode);
    endtask
    task automatic sc_tout();
        host(1'b1, normal_mode);
        step(TXM + 8);
        #1 `CHK(tx_en, 1'b0)
        `CHK(err_n, 1'b0)
        host(1'b0, normal_mode);
        rd(ADDR_STATUS, 16'h6880);
        host(1'b1, normal_mode);
        step(TXM + 8);
        host(1'b0, standby_mode);
        step(3);
        #1 `CHK(err_n, 1'b1)
        host(1'b0, normal_mode);
        step(3);
        rd(ADDR_STATUS, 16'h6000);
    endtask
    task automatic sc_ctrl();
        rd(ADDR_CTRL, 16'h0001);
        host(1'b1, normal_mode);
        step(4);
        #1 `CHK(tx_en, 1'b1)
        wr(ADDR_CTRL, 16'h0000);
        step(2);
        #1 `CHK(tx_en, 1'b0)
        wr(ADDR_CTRL, 16'h0001);
        step(2);
        #1 `CHK(tx_en, 1'b1)
        host(1'b0, normal_mode);
        step(2);
    endtask
    task automatic sc_modes();
        tfs_mode_t md [4] = '{receive_only_mode, standby_mode, sleep_mode,
            go_to_sleep_mode};
        logic [15:0] ex [4] = '{16'hc000, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            host(1'b0, md[i]);
            step(3);
            heat(1'b1, 1'b1);
            step(3);
            #1 `CHK(err_n, 1'b1)
            rd(ADDR_STATUS, ex[i]);
        end
        host(1'b0, normal_mode);
        step(3);
        rd(ADDR_STATUS, 16'h6000);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        step(4);
        rst_n <= 1'b1;
        sc_power();
        sc_warn();
        sc_shut();
        sc_tout();
        sc_ctrl();
        sc_modes();
        results();
    end
endmodule
`default_nettype wire
